// ---- hw/cbs_core.sv ----
// Snoop, hold, flush and pin qualification logic of the bus unit.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module cbs_core
  import cbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        snoop_addr_strobe_n,
  input  wire logic        snoop_kill_in,
  input  wire logic        addr_float_req,
  input  wire logic        hold_req,
  input  wire logic        backoff_n,
  input  wire logic        flush_n,
  input  wire logic        copyback_select,
  input  wire logic        cacheable_n,
  input  wire logic        burst_ack_n,
  input  wire logic        ready_n,
  input  wire logic        cycle_strobe_n,
  input  wire logic        maskable_irq,
  input  wire logic        irq_flag,
  input  wire logic        nmi,
  input  wire logic        fp_fault_bypass_n,
  input  wire logic        native_fp_error_bit,
  input  wire logic        fp_error,
  input  wire logic        fp_noncontrol,
  input  wire logic        paging_on,
  input  wire logic        page_attr,
  input  wire logic        cache_off_bit,
  input  wire logic        parity_bad,
  input  wire cbs_cycle_t  cyc,
  input  wire cbs_tag_t    tag,
  output logic             hold_grant,
  output logic             dirty_hit_n,
  output logic             dirty_hit_oe_n,
  output logic             snoop_take,
  output logic             snoop_kill,
  output logic             line_fill,
  output logic             line_store,
  output logic             flush_special,
  output logic             irq_ack_run,
  output logic             nmi_event,
  output logic             fp_freeze,
  output logic             fp_fault_n,
  output logic             fp_fault_oe_n,
  output logic             page_nocache,
  output logic             parity_fail_n,
  output logic             multi_cycle_n,
  output logic             addr_float,
  output logic             writeback_drive,
  output logic             tristate_test,
  output logic             copyback_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers. The trade-off is two clocks of
  // latency on each synchronised pin; the snoop timing below is counted after that.

  logic [1:0]  rst_sync;
  logic        rst_s;
  logic [11:0] sync_a;
  logic [11:0] sync_b;
  logic        p_snoop_addr_strobe_n_n, p_kill, p_addr_float_req, p_hold, p_backoff_n_n, p_flush_n;
  logic        p_wb, p_ken_n, p_burst_ack_n_n, p_rdy_n, p_irq, p_nmi, p_byp_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_s = rst_sync[1];

  // No reset here: the straps must reach the core while reset is held,
  // so these stages keep following the pins during reset.
  always_ff @(posedge clk) begin
    sync_a <= {snoop_addr_strobe_n, snoop_kill_in, addr_float_req, hold_req,
               backoff_n, flush_n, copyback_select, cacheable_n,
               burst_ack_n, ready_n, maskable_irq, nmi};
    sync_b <= sync_a;
  end
  assign {p_snoop_addr_strobe_n_n, p_kill, p_addr_float_req, p_hold, p_backoff_n_n, p_flush_n, p_wb,
          p_ken_n, p_burst_ack_n_n, p_rdy_n, p_irq, p_nmi} = sync_b;

  logic [1:0] byp_sync;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byp_sync <= 2'h3;
    end else begin
      byp_sync <= {byp_sync[0], fp_fault_bypass_n};
    end
  end
  assign p_byp_n = byp_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  cbs_state_t s;
  cbs_state_t next_s;
  logic       nmi_prev;
  logic       in_reset;
  logic       addr_float_req_ok, backoff_n_ok, hold_grant_ok, window, strobe;
  logic       done_last;

  always_comb begin
    next_s    = s;
    in_reset  = ~rst_s;
    done_last = ~p_burst_ack_n_n & cyc.last;
    next_s.snoop_take    = 1'b0;
    next_s.flush_special = 1'b0;
    next_s.fill          = 1'b0;
    next_s.store         = 1'b0;
    next_s.ken_prev      = ~p_ken_n;
    next_s.flush_prev    = p_flush_n;

    // Age counters give the first sample clock per trigger.
    next_s.addr_float_req_age = p_addr_float_req ? ((s.addr_float_req_age == 2'h3) ? s.addr_float_req_age
                       : s.addr_float_req_age + 2'h1) : AGE_RST;
    next_s.backoff_n_age  = ~p_backoff_n_n ? ((s.backoff_n_age == 2'h3) ? s.backoff_n_age
                       : s.backoff_n_age + 2'h1) : AGE_RST;
    next_s.hold_grant_age  = s.hold_grant;
    addr_float_req_ok = p_addr_float_req && (s.addr_float_req_age >= 2'(ADDR_FLOAT_REQ_FIRST - 1));
    backoff_n_ok  = ~p_backoff_n_n && (s.backoff_n_age >= 2'(BACKOFF_N_FIRST - 1));
    hold_grant_ok  = s.hold_grant && (s.hold_grant_age || (HOLD_GRANT_FIRST == 0));
    window   = addr_float_req_ok || backoff_n_ok || hold_grant_ok;
    strobe   = ~p_snoop_addr_strobe_n_n && window && s.dirty_hit_n && !s.block_next
               && (s.snoop == CBS_IDLE);
    next_s.block_next = strobe || ~cycle_strobe_n;

    case (s.snoop)
      CBS_IDLE: begin
        if (strobe) begin
          next_s.snoop_take = 1'b1;
          next_s.snoop_kill = p_kill & s.copyback;
          next_s.snoop      = CBS_LOOKUP;
        end else if (!s.flush_prev && p_flush_n && !in_reset) begin
          next_s.snoop = CBS_FLUSH;
        end
      end
      CBS_LOOKUP: begin
        // Lookup answers one clock after the take, so the low edge lands
        // two clocks after the strobe.
        if (tag.hit && tag.dirty && s.copyback) begin
          next_s.dirty_hit_n     = 1'b0;
          next_s.writeback_drive = 1'b1;
          next_s.snoop           = CBS_DIRTY;
        end else begin
          next_s.snoop = CBS_IDLE;
        end
      end
      CBS_DIRTY: begin
        if (done_last) begin
          next_s.dirty_hit_n     = 1'b1;
          next_s.writeback_drive = 1'b0;
          next_s.snoop           = CBS_IDLE;
        end
      end
      CBS_FLUSH: begin
        if (tag.flush_done) begin
          if (s.copyback && s.flush_acks != 2'(FLUSH_ACK_COUNT)) begin
            next_s.flush_special = 1'b1;
            next_s.flush_acks    = s.flush_acks + 2'h1;
          end else begin
            next_s.flush_acks = 2'h0;
            next_s.snoop      = CBS_IDLE;
          end
        end
      end
      default: next_s.snoop = CBS_IDLE;
    endcase

    // Hold is granted between cycles and never inside a locked run.
    if (s.hold_grant) begin
      next_s.hold_grant = p_hold;
    end else begin
      next_s.hold_grant = p_hold && !cyc.active && !cyc.locked;
    end
    next_s.addr_float = (p_addr_float_req || ~p_backoff_n_n || next_s.hold_grant)
                        && !next_s.writeback_drive;

    // Line fill qualification, never on a locked read.
    if (cyc.cacheable && !cyc.locked && s.ken_prev
        && (~p_burst_ack_n_n || ~p_rdy_n) && !cyc.multi) begin
      next_s.fill = 1'b1;
    end
    if (cyc.cacheable && !cyc.locked && s.ken_prev && done_last) begin
      next_s.store = 1'b1;
    end

    next_s.irq_ack  = p_irq && irq_flag;
    nmi_prev        = s.nmi_seen;
    next_s.nmi_seen = p_nmi && !nmi_prev && (s.nmi_low == 3'(NMI_LOW_MIN));
    next_s.nmi_low  = p_nmi ? NMI_CNT_RST : ((s.nmi_low == 3'(NMI_LOW_MIN))
                      ? s.nmi_low : s.nmi_low + 3'h1);

    next_s.fp_freeze  = fp_error && fp_noncontrol
                        && (native_fp_error_bit || p_byp_n);
    next_s.fp_fault_n = ~fp_error;
    next_s.page_nocache = (cycle_strobe_n) ? s.page_nocache
                          : (paging_on && page_attr && !cache_off_bit);
    next_s.parity_fail_n = !(cyc.read && ~p_rdy_n && parity_bad);
    next_s.multi_cycle_n = s.copyback ? 1'b1
                           : !(cyc.multi && !cyc.last);

    // Straps are caught while reset is still held.
    if (in_reset) begin
      next_s.copyback    = p_wb;
      next_s.tristate    = ~p_flush_n;
      next_s.dirty_hit_n = 1'b1;
      next_s.dirty_oe_n  = ~p_wb | ~p_flush_n;
      next_s.snoop       = CBS_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{snoop: CBS_IDLE, dirty_hit_n: 1'b1, dirty_oe_n: 1'b1,
             ken_prev: 1'b0, flush_prev: 1'b1, fp_fault_n: 1'b1,
             parity_fail_n: 1'b1, multi_cycle_n: 1'b1, addr_float_req_age: AGE_RST,
             backoff_n_age: AGE_RST, nmi_low: NMI_CNT_RST, flush_acks: 2'h0,
             default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign hold_grant      = s.hold_grant;
  assign dirty_hit_n     = s.dirty_hit_n;
  assign dirty_hit_oe_n  = s.dirty_oe_n;
  assign snoop_take      = s.snoop_take;
  assign snoop_kill      = s.snoop_kill;
  assign line_fill       = s.fill;
  assign line_store      = s.store;
  assign flush_special   = s.flush_special;
  assign irq_ack_run     = s.irq_ack;
  assign nmi_event       = s.nmi_seen;
  assign fp_freeze       = s.fp_freeze;
  assign fp_fault_n      = s.fp_fault_n;
  assign fp_fault_oe_n   = s.tristate;
  assign page_nocache    = s.page_nocache;
  assign parity_fail_n   = s.parity_fail_n;
  assign multi_cycle_n   = s.multi_cycle_n;
  assign addr_float      = s.addr_float;
  assign writeback_drive = s.writeback_drive;
  assign tristate_test   = s.tristate;
  assign copyback_mode   = s.copyback;

endmodule

// ---- hw/cbs_pkg.sv ----
// Shared constants and carrier types for the bus snoop and hold control.
package cbs_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned DIRTY_HIT_N_DELAY      = 2;
  localparam int unsigned ADDR_FLOAT_REQ_FIRST     = 2;
  localparam int unsigned HOLD_GRANT_FIRST      = 1;
  localparam int unsigned BACKOFF_N_FIRST      = 2;
  localparam int unsigned NMI_LOW_MIN     = 4;
  localparam int unsigned FLUSH_ACK_COUNT = 2;
  localparam logic [2:0]  NMI_CNT_RST     = 3'h0;
  localparam logic [1:0]  AGE_RST         = 2'h0;

  typedef enum logic [3:0] {
    CBS_IDLE   = 4'h1,
    CBS_LOOKUP = 4'h2,
    CBS_DIRTY  = 4'h4,
    CBS_FLUSH  = 4'h8
  } cbs_snoop_t;

  // One cycle seen from the core: what kind and whether it is locked.
  typedef struct packed {
    logic active;
    logic last;
    logic locked;
    logic read;
    logic multi;
    logic cacheable;
  } cbs_cycle_t;

  // Answers from the on-chip cache tag store.
  typedef struct packed {
    logic hit;
    logic dirty;
    logic flush_done;
    logic wb_done;
  } cbs_tag_t;

  typedef struct packed {
    cbs_snoop_t snoop;
    logic [1:0] addr_float_req_age;
    logic [1:0] backoff_n_age;
    logic       hold_grant_age;
    logic       block_next;
    logic       copyback;
    logic       tristate;
    logic       hold_grant;
    logic       dirty_hit_n;
    logic       dirty_oe_n;
    logic       snoop_take;
    logic       snoop_kill;
    logic       fill;
    logic       store;
    logic       ken_prev;
    logic       flush_prev;
    logic [1:0] flush_acks;
    logic       flush_special;
    logic       nmi_seen;
    logic [2:0] nmi_low;
    logic       irq_ack;
    logic       fp_freeze;
    logic       fp_fault_n;
    logic       page_nocache;
    logic       parity_fail_n;
    logic       multi_cycle_n;
    logic       addr_float;
    logic       writeback_drive;
  } cbs_state_t;

endpackage

// ---- verification/cbs_core_assertions.sv ----
// Port checker for the bus snoop and hold control.
`timescale 1ns/10ps
module cbs_core_assertions
  import cbs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       hold_req,
  input wire cbs_cycle_t cyc,
  input wire logic       hold_grant,
  input wire logic       dirty_hit_n,
  input wire logic       dirty_hit_oe_n,
  input wire logic       snoop_take,
  input wire logic       snoop_kill,
  input wire logic       fp_fault_oe_n,
  input wire logic       multi_cycle_n,
  input wire logic       tristate_test,
  input wire logic       copyback_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  AST_TAKE_SPACED:
    assert property (snoop_take |=> !snoop_take)
    else $error("snoop taken on two clocks in a row");
  AST_TAKE_NOT_DIRTY:
    assert property (snoop_take |-> $past(dirty_hit_n))
    else $error("snoop taken while dirty hit active");
  AST_WT_FLOAT:
    assert property (!copyback_mode |-> dirty_hit_oe_n)
    else $error("dirty hit driven in write-through");
  AST_HIT_DELAY:
    assert property ($fell(dirty_hit_n) |-> $past(snoop_take)
                     && copyback_mode)
    else $error("dirty hit not two clocks after strobe");
  AST_MULTI_HIGH:
    assert property (copyback_mode |-> multi_cycle_n)
    else $error("multi cycle low in copyback");
  AST_GRANT_DROP:
    assert property (!hold_req [*4] |-> !hold_grant)
    else $error("grant kept after hold dropped");
  AST_GRANT_UNLOCKED:
    assert property ($rose(hold_grant) |-> !$past(cyc.locked))
    else $error("grant given during locked cycle");
  AST_FAULT_DRIVEN:
    assert property (!tristate_test |-> !fp_fault_oe_n)
    else $error("fault output floated");
  AST_WT_NO_KILL:
    assert property (snoop_take && !copyback_mode |-> !snoop_kill)
    else $error("invalidate taken in write-through");
  ////////////////////////////////////////////////////////////////////////////
  cover property (snoop_take);
  cover property ($fell(dirty_hit_n));
  cover property ($rose(hold_grant));
endmodule

bind cbs_core cbs_core_assertions u_chk (.*);

// ---- verification/cbs_sys.sv ----
// Behavioural model of the chipset that snoops through bus hold.
`timescale 1ns/10ps
module cbs_sys (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic stray,
  input  wire logic kill,
  input  wire logic hold_grant,
  output logic      hold_req,
  output logic      snoop_addr_strobe_n,
  output logic      snoop_kill_in
);
  int i;
  // Strobe and invalidate idle at their pull-up level, never the last value.
  initial begin
    hold_req = 0;
    snoop_addr_strobe_n = 1;
    snoop_kill_in = 1;
    forever begin
      @(posedge clk);
      if (stray) begin
        snoop_addr_strobe_n <= 0;
        @(posedge clk);
        snoop_addr_strobe_n <= 1;
      end else if (go) begin
        hold_req <= 1;
        for (i = 0; i < 60 && !hold_grant; i++) @(posedge clk);
        @(posedge clk);
        snoop_addr_strobe_n <= 0;
        snoop_kill_in <= kill;
        @(posedge clk);
        snoop_addr_strobe_n <= 1;
        snoop_kill_in <= 1;
        while (go) @(posedge clk);
        hold_req <= 0;
      end
    end
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the bus snoop and hold control.
`timescale 1ns/10ps
module tb;
  import cbs_pkg::*;
  logic clk = 0, rstn = 0, addr_float_req = 0, backoff_n = 1, flush_n = 1;
  logic copyback_select = 1, cacheable_n = 1, burst_ack_n = 1, ready_n = 1;
  logic cycle_strobe_n = 1, maskable_irq = 0, irq_flag = 0, nmi = 0;
  logic fp_fault_bypass_n = 1, native_fp_error_bit = 0, fp_error = 0;
  logic fp_noncontrol = 0, paging_on = 0, page_attr = 0, cache_off_bit = 0;
  logic parity_bad = 0, go = 0, stray = 0, kill = 0;
  cbs_cycle_t cyc = '0;
  cbs_tag_t tag = '0;
  logic snoop_addr_strobe_n, snoop_kill_in, hold_req, hold_grant, dirty_hit_n;
  logic dirty_hit_oe_n, snoop_take, snoop_kill, line_fill, line_store;
  logic flush_special, irq_ack_run, nmi_event, fp_freeze, fp_fault_n;
  logic fp_fault_oe_n, page_nocache, parity_fail_n, multi_cycle_n, addr_float;
  logic writeback_drive, tristate_test, copyback_mode;
  int errors = 0, n_checks = 0;
  cbs_core DUT (.*);
  cbs_sys u_sys (.clk(clk), .go(go), .stray(stray), .kill(kill),
    .hold_grant(hold_grant), .hold_req(hold_req),
    .snoop_addr_strobe_n(snoop_addr_strobe_n),
    .snoop_kill_in(snoop_kill_in));
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Sampling 1 ns after the edge keeps reads clear of the edge's updates.
  task automatic cyc_n(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(logic mode);
    @(posedge clk);
    rstn <= 0;
    copyback_select <= mode;
    cyc_n(10);
    @(posedge clk);
    rstn <= 1;
    cyc_n(6);
    chk(copyback_mode, mode);
    chk(dirty_hit_oe_n, !mode);
    chk(dirty_hit_n, 1);
    chk(multi_cycle_n, 1);
    chk(fp_fault_oe_n, 0);
    chk(tristate_test, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic flush_count(output int n);
    n = 0;
    @(posedge clk);
    flush_n <= 0;
    tag <= '{flush_done: 1, default: 0};
    @(posedge clk);
    flush_n <= 1;
    repeat (10) begin
      cyc_n(1);
      n += flush_special;
    end
    tag <= '0;
  endtask
  task automatic fill_probe(input logic lk, input logic bu,
                            output logic f, output logic st);
    @(posedge clk);
    cyc <= '{active: 1, cacheable: 1, locked: lk, last: bu, default: 0};
    cacheable_n <= 0;
    @(posedge clk);
    if (bu) begin
      burst_ack_n <= 0;
    end else begin
      ready_n <= 0;
    end
    @(posedge clk);
    burst_ack_n <= 1;
    ready_n <= 1;
    cyc_n(2);
    f = line_fill;
    st = line_store;
    @(posedge clk);
    cyc <= '0;
    cacheable_n <= 1;
  endtask
  task automatic t_misc();
    int n;
    logic f, st;
    @(posedge clk);
    maskable_irq <= 1;
    irq_flag <= 1;
    fp_error <= 1;
    fp_noncontrol <= 1;
    addr_float_req <= 1;
    cyc_n(4);
    chk(irq_ack_run, 1);
    chk(fp_freeze, 1);
    chk(fp_fault_n, 0);
    chk(addr_float, 1);
    @(posedge clk);
    maskable_irq <= 0;
    fp_fault_bypass_n <= 0;
    addr_float_req <= 0;
    cyc_n(4);
    chk(irq_ack_run, 0);
    chk(fp_freeze, 0);
    chk(addr_float, 0);
    @(posedge clk);
    native_fp_error_bit <= 1;
    cyc_n(2);
    chk(fp_freeze, 1);
    @(posedge clk);
    fp_error <= 0;
    fp_noncontrol <= 0;
    native_fp_error_bit <= 0;
    fp_fault_bypass_n <= 1;
    irq_flag <= 0;
    nmi <= 1;
    cyc_n(3);
    chk(nmi_event, 1);
    chk(fp_fault_n, 1);
    cyc_n(1);
    chk(nmi_event, 0);
    @(posedge clk);
    nmi <= 0;
    cyc <= '{read: 1, default: 0};
    parity_bad <= 1;
    ready_n <= 0;
    @(posedge clk);
    ready_n <= 1;
    cyc_n(2);
    chk(parity_fail_n, 0);
    cyc_n(1);
    chk(parity_fail_n, 1);
    @(posedge clk);
    cyc <= '0;
    parity_bad <= 0;
    fill_probe(0, 0, f, st);
    chk(f, 1);
    fill_probe(1, 0, f, st);
    chk(f, 0);
    fill_probe(0, 1, f, st);
    chk(st, 1);
    flush_count(n);
    chk(n, FLUSH_ACK_COUNT);
    chk(tristate_test, 0);
  endtask
  task automatic t_pins();
    @(posedge clk);
    paging_on <= 1;
    page_attr <= 1;
    cycle_strobe_n <= 0;
    @(posedge clk);
    cycle_strobe_n <= 1;
    cyc_n(2);
    chk(page_nocache, 1);
    @(posedge clk);
    cache_off_bit <= 1;
    cycle_strobe_n <= 0;
    @(posedge clk);
    cycle_strobe_n <= 1;
    cyc_n(2);
    chk(page_nocache, 0);
    cache_off_bit <= 0;
  endtask
  task automatic t_stray();
    logic seen;
    seen = 0;
    @(posedge clk);
    stray <= 1;
    @(posedge clk);
    stray <= 0;
    repeat (8) begin
      cyc_n(1);
      seen |= snoop_take;
    end
    chk(seen, 0);
  endtask
  task automatic t_snoop();
    int i;
    @(posedge clk);
    tag <= '{hit: 1, dirty: 1, default: 0};
    cyc <= '{active: 1, locked: 1, default: 0};
    kill <= 1;
    go <= 1;
    cyc_n(8);
    chk(hold_grant, 0);
    @(posedge clk);
    cyc <= '0;
    for (i = 0; i < 40 && !snoop_take; i++) cyc_n(1);
    chk(snoop_take, 1);
    chk(snoop_kill, 1);
    cyc_n(2);
    chk(dirty_hit_n, 0);
    chk(writeback_drive, 1);
    chk(addr_float, 0);
    @(posedge clk);
    go <= 0;
    burst_ack_n <= 0;
    tag <= '{wb_done: 1, default: 0};
    cyc <= '{active: 1, last: 1, default: 0};
    @(posedge clk);
    burst_ack_n <= 1;
    cyc_n(3);
    cyc <= '0;
    tag <= '0;
    for (i = 0; i < 10 && !dirty_hit_n; i++) cyc_n(1);
    chk(dirty_hit_n, 1);
  endtask
  task automatic t_wt();
    int i;
    int n;
    do_reset(0);
    @(posedge clk);
    tag <= '{hit: 1, dirty: 1, default: 0};
    go <= 1;
    for (i = 0; i < 40 && !snoop_take; i++) cyc_n(1);
    chk(snoop_take, 1);
    chk(snoop_kill, 0);
    cyc_n(3);
    chk(dirty_hit_oe_n, 1);
    flush_count(n);
    chk(n, 0);
    @(posedge clk);
    go <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1);
    t_pins();
    t_misc();
    t_stray();
    t_snoop();
    t_wt();
    complete_run();
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
